// ===== src/wfc_pkg.sv
// constants and types shared by the watchdog fail counter design
package wfc_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 550_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int TRIG_PULSE_NS = 32_000;
  localparam int TRIG_PULSE_CYCLES = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_NS = 2_000_000;
  localparam int RESET_HOLD_CYCLES = RESET_HOLD_NS / CLK_PERIOD_NS;

  // register byte addresses
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_SFC = 5'h04;
  localparam logic [4:0] ADDR_WIN1 = 5'h08;
  localparam logic [4:0] ADDR_WIN2 = 5'h0c;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  localparam logic [4:0] ADDR_MASK = 5'h14;
  localparam logic [4:0] ADDR_STATE = 5'h18;
  localparam logic [4:0] ADDR_ANSWER = 5'h1c;

  // control register fields
  localparam int P_DRV_EN = 0;
  localparam int P_GO_ACTIVE = 1;
  // safety_function_config fields
  localparam int P_RST_EN = 3;
  localparam int P_QA_MODE = 5;
  // wdg_status_reg fields, mask uses the same layout
  localparam int P_EARLY = 0;
  localparam int P_TIMEOUT = 1;
  localparam int P_BAD = 2;
  localparam int P_RESET = 3;
  localparam int STATUS_W = 4;
  // state register fields
  localparam int P_FAIL_LSB = 0;
  localparam int P_IN_RANGE = 3;
  localparam int P_DEV_LSB = 4;
  localparam int P_WIN_OPEN = 6;
  // answer register field
  localparam int P_ANS_OK = 0;

  // window configuration
  localparam int WIN1_W = 7;
  localparam int WIN2_W = 5;
  localparam logic [WIN1_W-1:0] WIN1_DEFAULT = 7'h05;
  localparam logic [WIN2_W-1:0] WIN2_DEFAULT = 5'h03;

  // fail counter values
  localparam logic [2:0] FAIL_MAX = 3'h7;
  localparam logic [2:0] FAIL_OUT = 3'h5;
  localparam logic [2:0] FAIL_INIT = 3'h5;

  typedef enum logic [1:0] {
    DEV_RESET,
    DEV_DIAG,
    DEV_ACTIVE
  } wfc_dev_type;
endpackage

// ===== src/wfc_trig_qual.sv
// trigger deglitch: qualifies a high pulse at least as long as the pulse time
`timescale 1ns/1ps
module wfc_trig_qual (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic trig_in,
  output logic trig_pulse
);
  typedef struct packed {
    logic prev;
    logic [11:0] high_cnt;
    logic pulse;
  } wfc_qual_type;

  wfc_qual_type s_ff;
  wfc_qual_type nxt_s;

  // count high time, fire on falling edge only when long enough
  always_comb begin
    nxt_s = s_ff;
    nxt_s.prev = trig_in;
    nxt_s.pulse = 1'b0;
    if (trig_in && !s_ff.prev) begin
      nxt_s.high_cnt = 12'h001;
    end else if (trig_in && s_ff.high_cnt < 12'(wfc_pkg::TRIG_PULSE_CYCLES)) begin
      nxt_s.high_cnt = s_ff.high_cnt + 12'h001;
    end
    if (!trig_in && s_ff.prev) begin
      nxt_s.pulse = (s_ff.high_cnt >= 12'(wfc_pkg::TRIG_PULSE_CYCLES));
      nxt_s.high_cnt = 12'h000;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign trig_pulse = s_ff.pulse;
endmodule

// ===== src/wfc_watchdog.sv
// watchdog fail counter, window sequence, device state and register slave
// Operation
// - good event lowers fail count by one, never below zero.
// - bad event raises fail count by one, saturating at seven.
// - time-out raises fail count, saturating at seven, and sets timeout flag.
// - fail count five or more forces driver enable low.
// - fail count four or less releases driver enable, gated by control bit.
// - fail count updates the same whatever the reset enable bit.
// - fail count loaded with five entering diagnostic and entering active.
// - at seven with reset enable, next bad or time-out enters reset.
// - entering reset reloads fail count with five.
// - setting reset enable while count is seven enters reset at once.
// - after reset the watchdog runs in trigger mode.
// - trigger in closed window is bad, restarts sequence, sets early flag.
// - trigger in open window is good and restarts sequence.
// - trigger is a high pulse of at least 32 us, shorter ones rejected.
// - any window config write restarts sequence and raises fail count.
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module wfc_watchdog #(
  parameter int TICK_CYCLES = wfc_pkg::TICK_CYCLES,
  parameter int RESET_HOLD_CYCLES = wfc_pkg::RESET_HOLD_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic trigger_input,
  input wire logic other_error_in,
  output logic driver_enable_out,
  output logic mcu_reset_out,
  output logic irq_out
);
  typedef struct packed {
    wfc_pkg::wfc_dev_type st;
    logic [17:0] hold_cnt;
    logic [16:0] tick_cnt;
    logic win_open;
    logic [6:0] win_cnt;
    logic [2:0] fail;
    logic pend_up;
    logic pend_dn;
    logic rst_en_prev;
    logic drv_bit;
    logic rst_en;
    logic qa_mode;
    logic [wfc_pkg::WIN1_W-1:0] win1;
    logic [wfc_pkg::WIN2_W-1:0] win2;
    logic [wfc_pkg::STATUS_W-1:0] status;
    logic [wfc_pkg::STATUS_W-1:0] mask;
    logic ack;
    logic [31:0] rdata;
    logic drv_out;
    logic mcu_reset_out_out;
    logic irq;
  } wfc_state_type;

  wfc_state_type s_ff;
  wfc_state_type nxt_s;

  logic trig_pulse;
  logic tick;
  logic wr;
  logic wr_lo;
  logic wr_win;
  logic ev_in;
  logic ev_ok;
  logic ev_good;
  logic ev_up;
  logic ev_early;
  logic ev_tout;
  logic go_reset;
  logic up;
  logic dn;
  logic [31:0] rd;
  logic [wfc_pkg::STATUS_W-1:0] st_set;
  logic [wfc_pkg::STATUS_W-1:0] st_clr;

  // qualified trigger pulses from the processor pin
  wfc_trig_qual u_qual (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .trig_in(trigger_input),
    .trig_pulse(trig_pulse)
  );

  // read value of the addressed register
  always_comb begin
    rd = 32'h0;
    case (avs_address)
      wfc_pkg::ADDR_CTRL: rd[wfc_pkg::P_DRV_EN] = s_ff.drv_bit;
      wfc_pkg::ADDR_SFC: begin
        rd[wfc_pkg::P_RST_EN] = s_ff.rst_en;
        rd[wfc_pkg::P_QA_MODE] = s_ff.qa_mode;
      end
      wfc_pkg::ADDR_WIN1: rd[wfc_pkg::WIN1_W-1:0] = s_ff.win1;
      wfc_pkg::ADDR_WIN2: rd[wfc_pkg::WIN2_W-1:0] = s_ff.win2;
      wfc_pkg::ADDR_STATUS: rd[wfc_pkg::STATUS_W-1:0] = s_ff.status;
      wfc_pkg::ADDR_MASK: rd[wfc_pkg::STATUS_W-1:0] = s_ff.mask;
      wfc_pkg::ADDR_STATE: begin
        rd[wfc_pkg::P_FAIL_LSB +: 3] = s_ff.fail;
        rd[wfc_pkg::P_IN_RANGE] = (s_ff.fail < wfc_pkg::FAIL_OUT);
        rd[wfc_pkg::P_DEV_LSB +: 2] = s_ff.st;
        rd[wfc_pkg::P_WIN_OPEN] = s_ff.win_open;
      end
      default: rd = 32'h0;
    endcase
  end

  // next-state logic of the whole block
  always_comb begin
    nxt_s = s_ff;
    tick = 1'b0;
    ev_good = 1'b0;
    ev_up = 1'b0;
    ev_early = 1'b0;
    ev_tout = 1'b0;
    go_reset = 1'b0;
    st_set = '0;
    st_clr = '0;
    up = 1'b0;
    dn = 1'b0;

    // bus handshake: one wait cycle, then the access completes
    nxt_s.ack = (avs_read | avs_write) & ~s_ff.ack;
    wr = avs_write & s_ff.ack;
    wr_lo = wr & avs_byteenable[0];
    wr_win = wr && (avs_address == wfc_pkg::ADDR_WIN1 || avs_address == wfc_pkg::ADDR_WIN2);
    if (avs_read && !s_ff.ack) begin
      nxt_s.rdata = rd;
    end

    // answer write in answer mode, trigger pulse otherwise
    ev_in = s_ff.qa_mode ? (wr_lo && avs_address == wfc_pkg::ADDR_ANSWER) : trig_pulse;
    ev_ok = s_ff.qa_mode ? avs_writedata[wfc_pkg::P_ANS_OK] : 1'b1;

    // watchdog time step
    if (s_ff.tick_cnt >= 17'(TICK_CYCLES - 1)) begin
      nxt_s.tick_cnt = 17'h0;
      tick = 1'b1;
    end else begin
      nxt_s.tick_cnt = s_ff.tick_cnt + 17'h1;
    end

    // register writes
    if (wr_lo) begin
      case (avs_address)
        wfc_pkg::ADDR_CTRL: begin
          nxt_s.drv_bit = avs_writedata[wfc_pkg::P_DRV_EN];
          if (avs_writedata[wfc_pkg::P_GO_ACTIVE] && s_ff.st == wfc_pkg::DEV_DIAG) begin
            nxt_s.st = wfc_pkg::DEV_ACTIVE;
          end
        end
        wfc_pkg::ADDR_SFC: begin
          nxt_s.rst_en = avs_writedata[wfc_pkg::P_RST_EN];
          if (s_ff.st == wfc_pkg::DEV_DIAG) begin
            nxt_s.qa_mode = avs_writedata[wfc_pkg::P_QA_MODE];
          end
        end
        wfc_pkg::ADDR_WIN1: begin
          if (s_ff.st == wfc_pkg::DEV_DIAG) begin
            nxt_s.win1 = avs_writedata[wfc_pkg::WIN1_W-1:0];
          end
        end
        wfc_pkg::ADDR_WIN2: begin
          if (s_ff.st == wfc_pkg::DEV_DIAG) begin
            nxt_s.win2 = avs_writedata[wfc_pkg::WIN2_W-1:0];
          end
        end
        wfc_pkg::ADDR_STATUS: st_clr = avs_writedata[wfc_pkg::STATUS_W-1:0];
        wfc_pkg::ADDR_MASK: nxt_s.mask = avs_writedata[wfc_pkg::STATUS_W-1:0];
        default: ;
      endcase
    end

    // window sequence and event classification
    if (s_ff.st != wfc_pkg::DEV_RESET) begin
      if (wr_win) begin
        ev_up = 1'b1;
        nxt_s.win_open = 1'b0;
        nxt_s.win_cnt = 7'h0;
      end else if (ev_in) begin
        if (!s_ff.win_open || !ev_ok) begin
          ev_up = 1'b1;
          ev_early = !s_ff.win_open;
        end else begin
          ev_good = 1'b1;
        end
        nxt_s.win_open = 1'b0;
        nxt_s.win_cnt = 7'h0;
      end else if (tick) begin
        if (!s_ff.win_open) begin
          if (s_ff.win_cnt + 7'h1 >= s_ff.win1) begin
            nxt_s.win_open = 1'b1;
            nxt_s.win_cnt = 7'h0;
          end else begin
            nxt_s.win_cnt = s_ff.win_cnt + 7'h1;
          end
        end else if (s_ff.win_cnt >= {2'b00, s_ff.win2}) begin
          ev_tout = 1'b1;
          nxt_s.win_open = 1'b0;
          nxt_s.win_cnt = 7'h0;
        end else begin
          nxt_s.win_cnt = s_ff.win_cnt + 7'h1;
        end
      end
    end
    // status bits raised by this cycle's events
    st_set[wfc_pkg::P_EARLY] = ev_early;
    st_set[wfc_pkg::P_TIMEOUT] = ev_tout;
    st_set[wfc_pkg::P_BAD] = ev_up;

    // events wait for the next tick, one step per tick, raise wins
    up = s_ff.pend_up | ev_up | ev_tout;
    dn = s_ff.pend_dn | ev_good;
    if (tick) begin
      nxt_s.pend_up = 1'b0;
      nxt_s.pend_dn = 1'b0;
      if (up) begin
        if (s_ff.fail == wfc_pkg::FAIL_MAX) begin
          go_reset = s_ff.rst_en;
        end else begin
          nxt_s.fail = s_ff.fail + 3'h1;
        end
      end else if (dn && s_ff.fail != 3'h0) begin
        nxt_s.fail = s_ff.fail - 3'h1;
      end
    end else begin
      nxt_s.pend_up = up;
      nxt_s.pend_dn = dn;
    end

    // reset enable turned on while already saturated
    nxt_s.rst_en_prev = s_ff.rst_en;
    if (s_ff.rst_en && !s_ff.rst_en_prev && s_ff.fail == wfc_pkg::FAIL_MAX) begin
      go_reset = 1'b1;
    end

    // device state transitions
    if (s_ff.st == wfc_pkg::DEV_RESET) begin
      nxt_s.pend_up = 1'b0;
      nxt_s.pend_dn = 1'b0;
      if (s_ff.hold_cnt >= 18'(RESET_HOLD_CYCLES - 1)) begin
        nxt_s.st = wfc_pkg::DEV_DIAG;
        nxt_s.fail = wfc_pkg::FAIL_INIT;
        nxt_s.qa_mode = 1'b0;
        nxt_s.win1 = wfc_pkg::WIN1_DEFAULT;
        nxt_s.win2 = wfc_pkg::WIN2_DEFAULT;
        nxt_s.win_open = 1'b0;
        nxt_s.win_cnt = 7'h0;
      end else begin
        nxt_s.hold_cnt = s_ff.hold_cnt + 18'h1;
      end
    end else if (go_reset) begin
      nxt_s.st = wfc_pkg::DEV_RESET;
      nxt_s.fail = wfc_pkg::FAIL_INIT;
      nxt_s.hold_cnt = 18'h0;
      nxt_s.pend_up = 1'b0;
      nxt_s.pend_dn = 1'b0;
      st_set[wfc_pkg::P_RESET] = 1'b1;
    end else if (nxt_s.st == wfc_pkg::DEV_ACTIVE && s_ff.st == wfc_pkg::DEV_DIAG) begin
      nxt_s.fail = wfc_pkg::FAIL_INIT;
    end

    // sticky status, a set in the clearing cycle survives
    nxt_s.status = (s_ff.status & ~st_clr) | st_set;

    // registered outputs
    nxt_s.drv_out = s_ff.drv_bit && !other_error_in && (nxt_s.fail < wfc_pkg::FAIL_OUT)
                    && nxt_s.st != wfc_pkg::DEV_RESET;
    nxt_s.mcu_reset_out_out = (nxt_s.st != wfc_pkg::DEV_RESET);
    nxt_s.irq = |(nxt_s.status & nxt_s.mask);
  end

  // state register, device starts in reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.st <= wfc_pkg::DEV_RESET;
      s_ff.fail <= wfc_pkg::FAIL_INIT;
      s_ff.win1 <= wfc_pkg::WIN1_DEFAULT;
      s_ff.win2 <= wfc_pkg::WIN2_DEFAULT;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // waitrequest from the bus request and ack, read data and outputs straight from the state register
  assign avs_waitrequest = (avs_read | avs_write) & ~s_ff.ack;
  assign avs_readdata = s_ff.rdata;
  assign driver_enable_out = s_ff.drv_out;
  assign mcu_reset_out = s_ff.mcu_reset_out_out;
  assign irq_out = s_ff.irq;
endmodule

// ===== bench/wfc_monitor.sv
// port checker for the watchdog fail counter block
`timescale 1ns/1ps
module wfc_monitor #(
  parameter int TICK_CYCLES = 20,
  parameter int RESET_HOLD_CYCLES = 10
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic trigger_input,
  input wire logic other_error_in,
  input wire logic driver_enable_out,
  input wire logic mcu_reset_out,
  input wire logic irq_out
);
  int low_ff;
  // cycles the processor reset has been held low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_ff <= 0;
    end else begin
      low_ff <= mcu_reset_out ? 0 : low_ff + 1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // bus handshake and read data holding
  chk_wait_first: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("wait cycle wrong");
  chk_one_wait: assert property ((avs_read || avs_write) && !avs_waitrequest |=>
    avs_waitrequest || !(avs_read || avs_write)) else $error("accepted twice");
  chk_rdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data moved without read");
  // driver enable gating and processor reset
  chk_err_gate: assert property (other_error_in |=> !driver_enable_out)
    else $error("driver on during error");
  chk_rst_gate: assert property (!mcu_reset_out |-> !driver_enable_out)
    else $error("driver on during reset");
  chk_drv_rise: assert property ($rose(driver_enable_out) |->
    !$past(other_error_in) && mcu_reset_out) else $error("driver rose wrongly");
  chk_hold_len: assert property ($rose(mcu_reset_out) |->
    low_ff >= RESET_HOLD_CYCLES) else $error("reset too short");
  chk_init_low: assert property ($rose(mcu_reset_out) |->
    (!driver_enable_out) [*3]) else $error("driver on after reset");
endmodule
bind wfc_watchdog wfc_monitor #(.TICK_CYCLES(TICK_CYCLES),
  .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) wfc_monitor_i (.core_clk(core_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .trigger_input(trigger_input), .other_error_in(other_error_in),
  .driver_enable_out(driver_enable_out), .mcu_reset_out(mcu_reset_out), .irq_out(irq_out));

// ===== bench/wfc_mcu_model.sv
// processor model driving the watchdog trigger pin
`timescale 1ns/1ps
module wfc_mcu_model (
  input wire logic core_clk,
  output logic trigger_input
);
  // pin idles low; error monitor never used, trigger mode only
  initial trigger_input = 1'b0;
  // raise the pin and hold it for the given cycles
  task automatic trig_rise(input int hold);
    @(posedge core_clk);
    trigger_input <= 1'b1;
    repeat (hold) @(posedge core_clk);
  endtask
  // end the pulse
  task automatic trig_fall();
    @(posedge core_clk);
    trigger_input <= 1'b0;
  endtask
endmodule

// ===== bench/testbench.sv
// self-checking bench for the watchdog fail counter
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, trigger_input, driver_enable_out, mcu_reset_out, irq_out;
  logic other_error_in = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  int error_cnt = 0;
  int samples_checked = 0;
  // clock
  always #5 core_clk = ~core_clk;
  wfc_watchdog #(.TICK_CYCLES(200), .RESET_HOLD_CYCLES(10)) wfc_watchdog_i (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .trigger_input(trigger_input), .other_error_in(other_error_in),
    .driver_enable_out(driver_enable_out), .mcu_reset_out(mcu_reset_out), .irq_out(irq_out));
  wfc_mcu_model wfc_mcu_model_i (.core_clk(core_clk), .trigger_input(trigger_input));
  // verdict
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // compare and report
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      check("bus timeout", 32'h1, 32'h0);
      complete_run();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // poll a register until the masked value appears
  task automatic wait_reg(input string nm, input logic [4:0] a, input logic [31:0] m,
      input logic [31:0] e, input int lim);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== e && n < lim);
    check(nm, rd & m, e);
  endtask
  // wait for the processor reset pin to go low
  task automatic wait_rst(input int lim);
    int n;
    n = 0;
    while (mcu_reset_out !== 1'b0 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    check("mcu_reset_out", {31'h0, mcu_reset_out}, 32'h0);
  endtask
  // power up, diagnostic entry, unmapped read
  task automatic t_power();
    check("rst pin", {31'h0, mcu_reset_out}, 32'h0);
    wait_reg("state", wfc_pkg::ADDR_STATE, 32'h3f, 32'h15, 50);
    repeat (2) @(posedge core_clk);
    check("rst pin", {31'h0, mcu_reset_out}, 32'h1);
    wait_reg("unmapped", wfc_pkg::ADDR_ANSWER, 32'hffffffff, 32'h0, 1);
  endtask
  // config write is a bad event; interrupt raise and clear
  task automatic t_cfg_irq();
    wr(wfc_pkg::ADDR_CTRL, 32'h1);
    wr(wfc_pkg::ADDR_MASK, 32'h6);
    wr(wfc_pkg::ADDR_WIN2, 32'h1f);
    wait_reg("fail", wfc_pkg::ADDR_STATE, 32'h7, 32'h6, 200);
    wait_reg("bad flag", wfc_pkg::ADDR_STATUS, 32'h4, 32'h4, 1);
    check("irq", {31'h0, irq_out}, 32'h1);
    wr(wfc_pkg::ADDR_STATUS, 32'h4);
    repeat (2) @(posedge core_clk);
    check("irq", {31'h0, irq_out}, 32'h0);
  endtask
  // good triggers, short pulse, driver release and error block
  task automatic t_good();
    for (int i = 5; i >= 4; i--) begin
      wfc_mcu_model_i.trig_rise(3300);
      wfc_mcu_model_i.trig_fall();
      wait_reg("fail", wfc_pkg::ADDR_STATE, 32'hf, i + (i < 5 ? 8 : 0), 300);
    end
    repeat (2) @(posedge core_clk);
    check("drv", {31'h0, driver_enable_out}, 32'h1);
    wfc_mcu_model_i.trig_rise(100);
    wfc_mcu_model_i.trig_fall();
    repeat (600) @(posedge core_clk);
    wait_reg("fail", wfc_pkg::ADDR_STATE, 32'h7, 32'h4, 1);
    other_error_in <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("drv", {31'h0, driver_enable_out}, 32'h0);
    other_error_in <= 1'b0;
  endtask
  // trigger in closed window after a restart
  task automatic t_early();
    wfc_mcu_model_i.trig_rise(3300);
    wr(wfc_pkg::ADDR_WIN1, 32'h5);
    wait_reg("fail", wfc_pkg::ADDR_STATE, 32'h7, 32'h5, 200);
    check("drv", {31'h0, driver_enable_out}, 32'h0);
    wfc_mcu_model_i.trig_fall();
    wait_reg("fail", wfc_pkg::ADDR_STATE, 32'h7, 32'h6, 200);
    wait_reg("early", wfc_pkg::ADDR_STATUS, 32'h1, 32'h1, 1);
  endtask
  // active entry reload, then time-out
  task automatic t_active_to();
    wr(wfc_pkg::ADDR_CTRL, 32'h3);
    wait_reg("state", wfc_pkg::ADDR_STATE, 32'h37, 32'h25, 100);
    wr(wfc_pkg::ADDR_STATUS, 32'hf);
    wait_reg("timeout", wfc_pkg::ADDR_STATUS, 32'h2, 32'h2, 3500);
    wait_reg("fail", wfc_pkg::ADDR_STATE, 32'h7, 32'h6, 200);
    check("irq", {31'h0, irq_out}, 32'h1);
  endtask
  // reset enable at seven, then escalation on the next bad event
  task automatic t_escalate();
    wr(wfc_pkg::ADDR_WIN1, 32'h5);
    wait_reg("fail", wfc_pkg::ADDR_STATE, 32'h7, 32'h7, 200);
    wr(wfc_pkg::ADDR_SFC, 32'h8);
    wait_rst(10);
    wait_reg("state", wfc_pkg::ADDR_STATE, 32'h3f, 32'h15, 50);
    wait_reg("rst flag", wfc_pkg::ADDR_STATUS, 32'h8, 32'h8, 1);
    wr(wfc_pkg::ADDR_SFC, 32'h8);
    for (int i = 6; i <= 7; i++) begin
      wr(wfc_pkg::ADDR_WIN2, 32'h1f);
      wait_reg("fail", wfc_pkg::ADDR_STATE, 32'h7, i, 200);
    end
    wr(wfc_pkg::ADDR_WIN2, 32'h1f);
    wait_rst(300);
  endtask
  // byte enable, answer mode entry, early and good answers
  task automatic t_answer();
    wait_reg("state", wfc_pkg::ADDR_STATE, 32'h3f, 32'h15, 50);
    avs_byteenable <= 4'he;
    wr(wfc_pkg::ADDR_WIN2, 32'h1f);
    avs_byteenable <= 4'hf;
    wait_reg("fail", wfc_pkg::ADDR_STATE, 32'h7, 32'h6, 200);
    wait_reg("win2 kept", wfc_pkg::ADDR_WIN2, 32'h1f, 32'h3, 1);
    wr(wfc_pkg::ADDR_SFC, 32'h20);
    wait_reg("qa mode", wfc_pkg::ADDR_SFC, 32'h28, 32'h20, 1);
    wr(wfc_pkg::ADDR_ANSWER, 32'h1);
    wait_reg("fail", wfc_pkg::ADDR_STATE, 32'h7, 32'h7, 200);
    wait_reg("early", wfc_pkg::ADDR_STATUS, 32'h1, 32'h1, 1);
    wait_reg("open", wfc_pkg::ADDR_STATE, 32'h40, 32'h40, 600);
    wr(wfc_pkg::ADDR_ANSWER, 32'h1);
    wait_reg("fail", wfc_pkg::ADDR_STATE, 32'h7, 32'h6, 200);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_power();
    t_cfg_irq();
    t_good();
    t_early();
    t_active_to();
    t_escalate();
    t_answer();
    complete_run();
  end
endmodule
